// *** rtl/overfrequency_protection.sv ***
// The implementer's own choices: the placing of the registers and the Wishbone register port.
`include "ofp_map.svh"
`default_nettype none
module overfrequency_protection #(
    parameter int unsigned CLK_HZ      = `OFP_CLK_HZ,
    parameter int unsigned TICK_CYCLES = `OFP_TICK_CYCLES,
    parameter int unsigned UNOM_PEAK   = 16384
) (
    input  wire logic            clk_sys,    // System clock, 100 MHz
    input  wire logic            rst,        // Synchronous reset, active high
    input  wire logic            ce,         // Clock enable, freezes all state when low
    input  wire ofp_pkg::sample_t smp,       // Voltage samples with valid strobe
    input  wire logic            inhibit_in, // Blocking input, asynchronous pin
    input  wire logic            wb_cyc,     // Wishbone cycle
    input  wire logic            wb_stb,     // Wishbone strobe
    input  wire logic            wb_we,      // Wishbone write enable
    input  wire logic [7:0]      wb_adr,     // Wishbone byte address
    input  wire logic [3:0]      wb_sel,     // Wishbone byte selects
    input  wire logic [31:0]     wb_dat_w,   // Wishbone write data
    output logic      [31:0]     wb_dat_r,   // Wishbone read data
    output logic                 wb_ack,     // Wishbone acknowledge
    output logic                 pickup_out, // General start
    output logic                 trip_out    // General trip
);
    import ofp_pkg::*;

    // Clock rate times 1000, so a period in cycles divides it into a frequency in mHz.
    localparam logic [39:0] FREQ_NUM = 40'(CLK_HZ) * 40'd1000;

    // Out-of-range writes are pinned to the nearest legal setting.
    function automatic logic [31:0] clamp(input logic [31:0] v, input int unsigned lo, input int unsigned hi);
        logic [31:0] r;
        r = v;
        if (v < 32'(lo)) begin
            r = 32'(lo);
        end else if (v > 32'(hi)) begin
            r = 32'(hi);
        end
        return r;
    endfunction

    logic        inhibit_meta, inhibit_s, wb_req, v_neg_prev, v_seen, rise_x, fall_x, u_ok;
    logic        rise_done, fall_done, rise_ok, fall_ok, rise_to, fall_to, meas_evt, meas_valid;
    logic        freq_ok, freq_upd, over, below_rel, elem_on, start_q, trip_q, run;
    logic [2:0]  val_cnt, inv_cnt, over_cnt;
    logic [5:0]  dcnt;
    logic [13:0] ms_cnt;
    logic [16:0] vsel, vabs, peak_run, peak_held, raw_freq, freq_meas, fset_mhz, presc;
    logic [23:0] p_rise, p_fall, dden;
    logic [24:0] drem, rem_sh, rem_sub;
    logic [31:0] wr_ctrl, wr_fset, wr_ulim, wr_delay, sel_mask;
    logic [39:0] dnum, dquo;
    settings_t   cfg;
    div_state_t  dstate;

    // The blocking pin is asynchronous to clk_sys.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            inhibit_meta <= 1'b0;
            inhibit_s    <= 1'b0;
        end else if (ce) begin
            inhibit_meta <= inhibit_in;
            inhibit_s    <= inhibit_meta;
        end
    end

    assign wb_req   = wb_cyc & wb_stb & ~wb_ack;
    assign sel_mask = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
    assign wr_ctrl  = ({29'h0, cfg.src_line, cfg.start_only, cfg.enable} & ~sel_mask) | (wb_dat_w & sel_mask);
    assign wr_fset  = ({19'h0, cfg.start_freq} & ~sel_mask) | (wb_dat_w & sel_mask);
    assign wr_ulim  = ({25'h0, cfg.ulimit} & ~sel_mask) | (wb_dat_w & sel_mask);
    assign wr_delay = ({18'h0, cfg.delay_ms} & ~sel_mask) | (wb_dat_w & sel_mask);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cfg.enable     <= 1'b0;
            cfg.start_only <= 1'b0;
            cfg.src_line   <= 1'b0;
            cfg.start_freq <= `OFP_FSET_RST;
            cfg.ulimit     <= `OFP_ULIM_RST;
            cfg.delay_ms   <= `OFP_DELAY_RST;
        end else if (ce && wb_req && wb_we) begin
            case (wb_adr)
                `OFP_ADR_CTRL: begin
                    cfg.enable     <= wr_ctrl[`OFP_CTRL_EN];
                    cfg.start_only <= wr_ctrl[`OFP_CTRL_SONLY];
                    cfg.src_line   <= wr_ctrl[`OFP_CTRL_SRC];
                end
                `OFP_ADR_FSET:  cfg.start_freq <= 13'(clamp(wr_fset, `OFP_FSET_MIN, `OFP_FSET_MAX));
                `OFP_ADR_ULIM:  cfg.ulimit <= 7'(clamp(wr_ulim, `OFP_ULIM_MIN, `OFP_ULIM_MAX));
                `OFP_ADR_DELAY: cfg.delay_ms <= 14'(clamp(wr_delay, `OFP_DELAY_MIN, `OFP_DELAY_MAX));
                default: ;
            endcase
        end
    end

    // Unmapped addresses still acknowledge and read as zero, so a stray access never hangs the bus.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            wb_ack   <= 1'b0;
            wb_dat_r <= 32'h0000_0000;
        end else if (ce) begin
            wb_ack <= wb_req;
            if (wb_req && !wb_we) begin
                case (wb_adr)
                    `OFP_ADR_CTRL:   wb_dat_r <= {29'h0, cfg.src_line, cfg.start_only, cfg.enable};
                    `OFP_ADR_FSET:   wb_dat_r <= {19'h0, cfg.start_freq};
                    `OFP_ADR_ULIM:   wb_dat_r <= {25'h0, cfg.ulimit};
                    `OFP_ADR_DELAY:  wb_dat_r <= {18'h0, cfg.delay_ms};
                    `OFP_ADR_STATUS: wb_dat_r <= {27'h0, inhibit_s, u_ok, freq_ok, trip_q, start_q};
                    `OFP_ADR_FREQ:   wb_dat_r <= {15'h0, freq_meas};
                    default:         wb_dat_r <= 32'h0000_0000;
                endcase
            end
        end
    end

    assign vsel = cfg.src_line ? ({smp.ch_a[15], smp.ch_a} - {smp.ch_b[15], smp.ch_b})
                               : {smp.ch_a[15], smp.ch_a};
    assign vabs = vsel[16] ? (17'h0 - vsel) : vsel;

    assign rise_x = smp.valid & v_seen & v_neg_prev & ~vsel[16];
    assign fall_x = smp.valid & v_seen & ~v_neg_prev & vsel[16];

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            v_neg_prev <= 1'b0;
            v_seen     <= 1'b0;
        end else if (ce && smp.valid) begin
            v_neg_prev <= vsel[16];
            v_seen     <= 1'b1;
        end
    end

    // Peak magnitude over each half cycle; lost crossings drop the held level to zero.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            peak_run  <= 17'h0_0000;
            peak_held <= 17'h0_0000;
        end else if (ce) begin
            if (rise_to || fall_to) begin
                peak_held <= 17'h0_0000;
            end
            if (rise_x || fall_x) begin
                peak_held <= (vabs > peak_run) ? vabs : peak_run;
                peak_run  <= vabs;
            end else if (smp.valid && vabs > peak_run) begin
                peak_run <= vabs;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            u_ok <= 1'b0;
        end else if (ce) begin
            u_ok <= (25'(peak_held) * 25'd100) >= (25'(cfg.ulimit) * 25'(UNOM_PEAK));
        end
    end

    period_timer #(.W(24), .PMIN(CLK_HZ / `OFP_FMAX_HZ), .PMAX(CLK_HZ / `OFP_FMIN_HZ)) u_rise (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .edge_in(rise_x),
        .period(p_rise), .done(rise_done), .in_range(rise_ok), .timeout(rise_to));

    period_timer #(.W(24), .PMIN(CLK_HZ / `OFP_FMAX_HZ), .PMAX(CLK_HZ / `OFP_FMIN_HZ)) u_fall (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .edge_in(fall_x),
        .period(p_fall), .done(fall_done), .in_range(fall_ok), .timeout(fall_to));

    assign rem_sh  = {drem[23:0], dnum[39]};
    assign rem_sub = rem_sh - {1'b0, dden};

    // Restoring divider, one quotient bit per cycle over 40 cycles; a crossing that comes while it runs is not measured.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            dstate <= DIV_IDLE;
            dnum   <= 40'h00_0000_0000;
            dquo   <= 40'h00_0000_0000;
            drem   <= 25'h000_0000;
            dden   <= 24'h00_0000;
            dcnt   <= 6'h00;
        end else if (ce) begin
            case (dstate)
                DIV_IDLE: begin
                    if (rise_done || fall_done) begin
                        dden   <= 24'((25'(p_rise) + 25'(p_fall)) >> 1);
                        dnum   <= FREQ_NUM;
                        dquo   <= 40'h00_0000_0000;
                        drem   <= 25'h000_0000;
                        dcnt   <= 6'h00;
                        dstate <= DIV_RUN;
                    end
                end
                DIV_RUN: begin
                    dnum <= {dnum[38:0], 1'b0};
                    if (!rem_sub[24]) begin
                        drem <= rem_sub;
                        dquo <= {dquo[38:0], 1'b1};
                    end else begin
                        drem <= rem_sh;
                        dquo <= {dquo[38:0], 1'b0};
                    end
                    dcnt <= dcnt + 6'h01;
                    if (dcnt == 6'h27) begin
                        dstate <= DIV_DONE;
                    end
                end
                DIV_DONE: dstate <= DIV_IDLE;
                default:  dstate <= DIV_IDLE;
            endcase
        end
    end

    assign raw_freq   = (dquo[39:17] != 23'h00_0000) ? 17'h1_ffff : dquo[16:0];
    assign meas_evt   = (dstate == DIV_DONE) | rise_to | fall_to;
    assign meas_valid = (dstate == DIV_DONE) & rise_ok & fall_ok & u_ok & (dden != 24'h00_0000);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            val_cnt   <= 3'h0;
            inv_cnt   <= 3'h0;
            freq_ok   <= 1'b0;
            freq_meas <= 17'h0_0000;
            freq_upd  <= 1'b0;
        end else if (ce) begin
            freq_upd <= 1'b0;
            if (meas_evt) begin
                if (meas_valid) begin
                    inv_cnt <= 3'h0;
                    if (val_cnt >= `OFP_VALID_NEED - 3'h1) begin
                        val_cnt   <= `OFP_VALID_NEED;
                        freq_meas <= raw_freq;
                        freq_ok   <= 1'b1;
                        freq_upd  <= 1'b1;
                    end else begin
                        val_cnt <= val_cnt + 3'h1;
                    end
                end else begin
                    val_cnt <= 3'h0;
                    if (inv_cnt >= `OFP_INVAL_NEED - 3'h1) begin
                        inv_cnt   <= `OFP_INVAL_NEED;
                        freq_meas <= 17'h0_0000;
                        freq_ok   <= 1'b0;
                        freq_upd  <= 1'b1;
                    end else begin
                        inv_cnt <= inv_cnt + 3'h1;
                    end
                end
            end
        end
    end

    assign fset_mhz  = 17'(cfg.start_freq * 17'd10);
    assign over      = freq_meas > fset_mhz;
    assign below_rel = freq_meas < (fset_mhz - `OFP_HYST_MHZ);
    assign elem_on   = cfg.enable & ~inhibit_s & u_ok;

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            over_cnt <= 3'h0;
        end else if (ce) begin
            if (!elem_on) begin
                over_cnt <= 3'h0;
            end else if (freq_upd) begin
                if (!over) begin
                    over_cnt <= 3'h0;
                end else if (over_cnt < `OFP_OVER_NEED) begin
                    over_cnt <= over_cnt + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            start_q <= 1'b0;
        end else if (ce) begin
            if (!elem_on) begin
                start_q <= 1'b0;
            end else if (freq_upd) begin
                if (over && over_cnt >= `OFP_OVER_NEED - 3'h1) begin
                    start_q <= 1'b1;
                end else if (below_rel) begin
                    start_q <= 1'b0;
                end
            end
        end
    end

    // timing starts at first faulty value
    assign run = elem_on & ((over_cnt != 3'h0) | start_q);

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            presc  <= 17'h0_0000;
            ms_cnt <= 14'h0000;
        end else if (ce) begin
            if (!run) begin
                presc  <= 17'h0_0000;
                ms_cnt <= 14'h0000;
            end else if (presc >= 17'(TICK_CYCLES - 1)) begin
                presc <= 17'h0_0000;
                if (ms_cnt != 14'h3fff) begin
                    ms_cnt <= ms_cnt + 14'h0001;
                end
            end else begin
                presc <= presc + 17'h0_0001;
            end
        end
    end

    // The delay includes measurement time, so short settings give a less exact trip instant.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            trip_q <= 1'b0;
        end else if (ce) begin
            trip_q <= run & start_q & ~cfg.start_only & (ms_cnt >= cfg.delay_ms);
        end
    end

    assign pickup_out = start_q;
    assign trip_out   = trip_q;

endmodule // overfrequency_protection
`default_nettype wire

// *** rtl/ofp_map.svh ***
`ifndef OFP_MAP_SVH
`define OFP_MAP_SVH

// Register byte offsets on the Wishbone slave.
`define OFP_ADR_CTRL    8'h00
`define OFP_ADR_FSET    8'h04
`define OFP_ADR_ULIM    8'h08
`define OFP_ADR_DELAY   8'h0C
`define OFP_ADR_STATUS  8'h10
`define OFP_ADR_FREQ    8'h14

// Control register bit positions.
`define OFP_CTRL_EN     0
`define OFP_CTRL_SONLY  1
`define OFP_CTRL_SRC    2

// Status register bit positions.
`define OFP_ST_PICKUP   0
`define OFP_ST_TRIP     1
`define OFP_ST_FREQOK   2
`define OFP_ST_UOK      3
`define OFP_ST_INHIBIT  4

// Setting reset values and ranges (frequency in 0.01 Hz, U limit in 0.01 Un, delay in ms).
`define OFP_FSET_RST    13'd5100
`define OFP_FSET_MIN    4000
`define OFP_FSET_MAX    7000
`define OFP_ULIM_RST    7'd45
`define OFP_ULIM_MIN    10
`define OFP_ULIM_MAX    100
`define OFP_DELAY_RST   14'd200
`define OFP_DELAY_MIN   140
`define OFP_DELAY_MAX   10000

// Measurement qualification counts and release hysteresis in mHz.
`define OFP_VALID_NEED  3'd4
`define OFP_INVAL_NEED  3'd4
`define OFP_OVER_NEED   3'd5
`define OFP_HYST_MHZ    17'd101

// Time base.
`define OFP_CLK_HZ      100000000
`define OFP_TICK_US     1000
`define OFP_TICK_CYCLES ((`OFP_CLK_HZ / 1000000) * `OFP_TICK_US)

// Period window accepted as a plausible power-system cycle.
`define OFP_FMIN_HZ     35
`define OFP_FMAX_HZ     75
`define OFP_PMIN_CYC    (`OFP_CLK_HZ / `OFP_FMAX_HZ)
`define OFP_PMAX_CYC    (`OFP_CLK_HZ / `OFP_FMIN_HZ)

// Clock rate times 1000 gives frequency in mHz when divided by a period in cycles.
`define OFP_FREQ_NUM    (40'(`OFP_CLK_HZ) * 40'd1000)

`endif

// *** rtl/ofp_pkg.sv ***
`default_nettype none
package ofp_pkg;

    typedef struct packed {
        logic               valid;
        logic signed [15:0] ch_a;
        logic signed [15:0] ch_b;
    } sample_t;

    typedef struct packed {
        logic        enable;
        logic        start_only;
        logic        src_line;
        logic [12:0] start_freq;
        logic [6:0]  ulimit;
        logic [13:0] delay_ms;
    } settings_t;

    typedef enum logic [1:0] {
        DIV_IDLE = 2'b00,
        DIV_RUN  = 2'b01,
        DIV_DONE = 2'b11
    } div_state_t;

endpackage
`default_nettype wire

// *** rtl/period_timer.sv ***
`default_nettype none
module period_timer #(
    parameter int unsigned W    = 24,
    parameter int unsigned PMIN = 1333333,
    parameter int unsigned PMAX = 2857142
) (
    input  wire logic         clk_sys,  // System clock
    input  wire logic         rst,      // Synchronous reset
    input  wire logic         ce,       // Clock enable
    input  wire logic         edge_in,  // Crossing pulse
    output logic [W-1:0]      period,   // Last period in cycles
    output logic              done,     // New period pulse
    output logic              in_range, // Last period plausible
    output logic              timeout   // No crossing within PMAX
);

    logic [W-1:0] cnt;
    logic         armed;

    // The first crossing after reset only arms the counter, it has no start point.
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            cnt      <= '0;
            armed    <= 1'b0;
            period   <= '0;
            done     <= 1'b0;
            in_range <= 1'b0;
            timeout  <= 1'b0;
        end else if (ce) begin
            done    <= 1'b0;
            timeout <= 1'b0;
            if (edge_in) begin
                cnt   <= W'(1);
                armed <= 1'b1;
                if (armed) begin
                    period   <= cnt;
                    done     <= 1'b1;
                    in_range <= (cnt >= W'(PMIN)) && (cnt <= W'(PMAX));
                end
            end else if (cnt >= W'(PMAX)) begin
                cnt      <= W'(1);
                timeout  <= 1'b1;
                in_range <= 1'b0;
            end else begin
                cnt <= cnt + W'(1);
            end
        end
    end

endmodule // period_timer
`default_nettype wire

// *** verif/ofp_chk_sva.sv ***
`default_nettype none
module ofp_chk (
    input wire logic        clk_sys,    // System clock
    input wire logic        rst,        // Synchronous reset
    input wire logic        ce,         // Clock enable
    input wire logic        inhibit_in, // Blocking input
    input wire logic        wb_cyc,     // Bus cycle
    input wire logic        wb_stb,     // Bus strobe
    input wire logic        wb_we,      // Bus write enable
    input wire logic [7:0]  wb_adr,     // Bus address
    input wire logic [31:0] wb_dat_r,   // Bus read data
    input wire logic        wb_ack,     // Bus acknowledge
    input wire logic        pickup_out, // General start
    input wire logic        trip_out    // General trip
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    chk_ack_latency: assert property (ce && wb_cyc && wb_stb && !wb_ack |=> wb_ack)
        else $error("ack missing one cycle after request");
    chk_ack_pulse: assert property (wb_ack && ce |=> !wb_ack)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property ($rose(wb_ack) |-> $past(wb_cyc) && $past(wb_stb))
        else $error("ack without request");
    chk_reset_quiet: assert property ($past(rst) |-> !wb_ack && wb_dat_r == 32'h0000_0000 && !pickup_out && !trip_out)
        else $error("outputs not cleared by reset");
    // Read data only moves with a read answer, so a stale word is never mistaken for fresh.
    chk_data_hold: assert property ($changed(wb_dat_r) |-> wb_ack && !wb_we)
        else $error("read data changed outside a read");
    chk_unmapped_zero: assert property (wb_ack && !wb_we && wb_adr > 8'h14 |-> wb_dat_r == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_inhibit_block: assert property (inhibit_in [*4] |-> !pickup_out && !trip_out)
        else $error("output active while blocked");
    chk_trip_pickup: assert property (trip_out |-> $past(pickup_out))
        else $error("trip without start");

    cover property (wb_ack && !wb_we);
    cover property (inhibit_in [*4]);
    cover property (wb_ack && wb_adr > 8'h14);
    cover property (trip_out);
endmodule // ofp_chk

bind overfrequency_protection ofp_chk chk (.clk_sys(clk_sys), .rst(rst), .ce(ce), .inhibit_in(inhibit_in),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .pickup_out(pickup_out), .trip_out(trip_out));
`default_nettype wire

// *** verif/sig_source.sv ***
`default_nettype none
module sig_source (
    input  wire logic               clk_sys, // System clock
    input  wire logic               rst,     // Synchronous reset
    input  wire logic signed [15:0] amp_a,   // Channel A amplitude
    input  wire logic signed [15:0] amp_b,   // Channel B amplitude
    output var  ofp_pkg::sample_t   smp      // Sample stream
);
    import ofp_pkg::*;
    logic [1:0]         div;
    logic [2:0]         step;
    logic               neg;
    logic               v;
    logic signed [15:0] va;
    logic signed [15:0] vb;
    assign v = (div == 2'h3);
    assign va = neg ? -amp_a : amp_a;
    assign vb = neg ? amp_b : -amp_b;
    // Between strobes the lines carry the complement, so a stale sample cannot pass as a new one.
    assign smp = {v, v ? va : ~va, v ? vb : ~vb};
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            div <= 2'h0;
            step <= 3'h0;
            neg <= 1'b0;
        end else begin
            div <= div + 2'h1;
            if (v) begin
                step <= step + 3'h1;
                if (step == 3'h7) begin
                    neg <= !neg;
                end
            end
        end
    end
endmodule // sig_source
`default_nettype wire

// *** verif/tb_top.sv ***
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ofp_pkg::*;
    logic               clk_sys, rst, ce, inhibit_in, wb_cyc, wb_stb, wb_we, wb_ack, pickup_out, trip_out;
    logic [7:0]         wb_adr;
    logic [3:0]         wb_sel;
    logic [31:0]        wb_dat_w, wb_dat_r, rd;
    logic signed [15:0] amp_a, amp_b;
    sample_t            smp;
    int                 mismatches = 0;
    int                 checks_done = 0;

    // A slow model clock makes the 64-cycle source period read as 51.562 Hz.
    overfrequency_protection #(.CLK_HZ(3300), .TICK_CYCLES(10), .UNOM_PEAK(16384)) dut (
        .clk_sys(clk_sys), .rst(rst), .ce(ce), .smp(smp), .inhibit_in(inhibit_in), .wb_cyc(wb_cyc),
        .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w),
        .wb_dat_r(wb_dat_r), .wb_ack(wb_ack), .pickup_out(pickup_out), .trip_out(trip_out));
    sig_source src (.clk_sys(clk_sys), .rst(rst), .amp_a(amp_a), .amp_b(amp_b), .smp(smp));

    task automatic complete_run();
        $display("Counts: %0d checks, %0d mismatches", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat, output logic [31:0] q);
        int n;
        n = 0;
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= we;
        wb_adr <= adr;
        wb_sel <= 4'hF;
        wb_dat_w <= dat;
        @(posedge clk_sys);
        while (wb_ack !== 1'b1 && n < 50) begin
            @(posedge clk_sys);
            n++;
        end
        if (n == 50) begin
            mismatches++;
            $display("Error ack expected 1 seen timeout");
        end
        q = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic rdchk(input string what, input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] q;
        wb_xfer(1'b0, adr, 32'h0000_0000, q);
        check(what, exp, q);
    endtask

    task automatic t_defaults();
        rdchk("ctrl", 8'h00, 32'h0000_0000);
        rdchk("start_freq", 8'h04, 32'h0000_13EC);
        rdchk("ulimit", 8'h08, 32'h0000_002D);
        rdchk("delay", 8'h0C, 32'h0000_00C8);
        rdchk("status", 8'h10, 32'h0000_0000);
        rdchk("freq", 8'h14, 32'h0000_0000);
        $display("test defaults done");
    endtask

    task automatic t_limits();
        logic [7:0]  a [9] = '{8'h04, 8'h04, 8'h04, 8'h08, 8'h08, 8'h08, 8'h0C, 8'h0C, 8'h0C};
        logic [31:0] w [9] = '{32'h0BB8, 32'h1F40, 32'h1403, 32'h5, 32'h78, 32'h63, 32'h64, 32'h2EE0, 32'h8D};
        logic [31:0] e [9] = '{32'h0FA0, 32'h1B58, 32'h1403, 32'hA, 32'h64, 32'h63, 32'h8C, 32'h2710, 32'h8D};
        for (int i = 0; i < 9; i++) begin
            wb_xfer(1'b1, a[i], w[i], rd);
            rdchk("setting", a[i], e[i]);
        end
        wb_xfer(1'b1, 8'h18, 32'hFFFF_FFFF, rd);
        rdchk("unmapped", 8'h18, 32'h0000_0000);
        $display("test limits done");
    endtask

    task automatic t_voltage();
        amp_a <= 16'sd16384;
        wb_xfer(1'b1, 8'h04, 32'h0000_1B58, rd);
        wb_xfer(1'b1, 8'h08, 32'h0000_002D, rd);
        wb_xfer(1'b1, 8'h00, 32'h0000_0001, rd);
        repeat (1000) @(posedge clk_sys);
        // A 70 Hz setting keeps start quiet while four valid periods qualify the value.
        rdchk("status", 8'h10, 32'h0000_000C);
        rdchk("freq", 8'h14, 32'h0000_C96A);
        amp_a <= 16'sd8000;
        wb_xfer(1'b1, 8'h08, 32'h0000_0064, rd);
        repeat (1000) @(posedge clk_sys);
        rdchk("status", 8'h10, 32'h0000_0000);
        rdchk("freq", 8'h14, 32'h0000_0000);
        amp_b <= 16'sd10000;
        wb_xfer(1'b1, 8'h00, 32'h0000_0005, rd);
        repeat (1000) @(posedge clk_sys);
        rdchk("status", 8'h10, 32'h0000_000C);
        $display("test voltage done");
    endtask

    task automatic t_inhibit();
        inhibit_in <= 1'b1;
        repeat (6) @(posedge clk_sys);
        rdchk("status", 8'h10, 32'h0000_001C);
        check("pickup", 32'h0000_0000, {31'h0, pickup_out});
        inhibit_in <= 1'b0;
        repeat (6) @(posedge clk_sys);
        rdchk("status", 8'h10, 32'h0000_000C);
        $display("test inhibit done");
    endtask

    // 51.562 Hz against 51.50 Hz: start after five values, trip 141 ms after the first one.
    task automatic t_trip();
        wb_xfer(1'b1, 8'h04, 32'h0000_141E, rd);
        repeat (450) @(posedge clk_sys);
        rdchk("status", 8'h10, 32'h0000_000D);
        repeat (1300) @(posedge clk_sys);
        rdchk("status", 8'h10, 32'h0000_000F);
        check("trip", 32'h0000_0001, {31'h0, trip_out});
        wb_xfer(1'b1, 8'h00, 32'h0000_0007, rd);
        rdchk("status", 8'h10, 32'h0000_000D);
        wb_xfer(1'b1, 8'h04, 32'h0000_1428, rd);
        repeat (200) @(posedge clk_sys);
        rdchk("status", 8'h10, 32'h0000_000D);
        wb_xfer(1'b1, 8'h04, 32'h0000_1432, rd);
        repeat (200) @(posedge clk_sys);
        rdchk("status", 8'h10, 32'h0000_000C);
        check("pickup", 32'h0000_0000, {31'h0, pickup_out});
        $display("test trip done");
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        repeat (20000) @(posedge clk_sys);
        mismatches++;
        $display("Error watchdog expected finish seen timeout");
        complete_run();
    end

    initial begin
        {rst, ce, inhibit_in, wb_cyc, wb_stb, wb_we} = 6'b110000;
        {wb_adr, wb_sel, wb_dat_w, amp_a, amp_b} = '0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        t_defaults();
        t_limits();
        t_voltage();
        t_inhibit();
        t_trip();
        complete_run();
    end
endmodule // tb_top
`default_nettype wire
